// *** hw/ssc_pkg.sv ***
// constants, register layouts and state types of the serial port control block
package ssc_pkg;
  localparam logic [7:0] IDX_CTRL_A = 8'h0e;
  localparam logic [7:0] IDX_CTRL_B = 8'h0f;
  localparam logic [7:0] IDX_STATUS = 8'h10;
  localparam logic [7:0] IDX_DATA = 8'h11;
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'hc0;
  localparam logic [7:0] CTRL_A_WMASK = 8'h5f;
  localparam logic [3:0] LEN_8 = 4'ha;
  localparam logic [3:0] LEN_9 = 4'hb;
  localparam logic [3:0] DATA_8 = 4'h8;
  localparam logic [3:0] DATA_9 = 4'h9;
  localparam logic [3:0] OSR_LAST = 4'hf;
  localparam logic [3:0] OSR_VOTE = 4'h9;
  localparam logic [3:0] RX_PH_START = 4'h1;
  localparam int TXSH_W = 11;
  typedef struct packed {
    logic rxNinth;
    logic txNinth;
    logic spare;
    logic charLen;
    logic rouse;
    logic pol;
    logic pha;
    logic finalClk;
  } ssc_ctrl_a_s;
  typedef struct packed {
    logic txeIe;
    logic tx_done_int_en;
    logic rxIe;
    logic quietIe;
    logic txEn;
    logic rxEn;
    logic sleep;
    logic brk;
  } ssc_ctrl_b_s;
  typedef struct packed {
    logic txEmpty;
    logic txDone;
    logic rxFull;
    logic quiet;
    logic overrun;
    logic noise;
    logic frameErr;
    logic spare;
  } ssc_status_s;
  typedef enum logic [2:0] {
    TX_OFF = 3'b000,
    TX_IDLE = 3'b001,
    TX_PRE = 3'b010,
    TX_DATA = 3'b011,
    TX_BRK = 3'b100,
    TX_MARK = 3'b101
  } ssc_tx_e;
  typedef enum logic {
    RX_HUNT = 1'b0,
    RX_BITS = 1'b1
  } ssc_rx_e;
endpackage

// *** hw/ssc_serial_port_control.sv ***
// serial port control: control registers, transmitter, receiver and status over apb
// Notes on behaviour
// - in nine-bit format the received ninth bit lands with the byte.
// - the ninth transmit bit is loaded into the shifter with the byte.
// - one length bit sets 8 or 9 data bits for both directions.
// - idle-line wake clears sleep after 10 or 11 consecutive ones.
// - sleep cannot be set in idle-line mode while the line is idle.
// - address-mark wake on a set MSB, clears sleep, stores byte, sets full.
// - sleep blocks receiver flags from setting, except on an address-mark wake, but clears none.
// - sync clock rests at the polarity level outside data bits.
// - phase selects clock edge at start or middle of each data bit.
// - the last data bit is clocked only when final-bit clock is enabled.
// - enabling the transmitter drives the pins and sends a preamble.
// - disabling mid-character finishes it before releasing the pins.
// - re-enable during a character queues a fresh preamble after it.
// - receiver disabled keeps all receiver flags from setting.
// - each flag but noise and frame error reaches the interrupt only through its enable bit; overrun shares the receive enable.
// - a break pulse sends one block of 10 or 11 zeros.
// - a held break repeats whole blocks, then at least one high bit.
// - no sync clock pulses during start and stop bits.
// - no sync clock while idle, in preamble or in break.
`timescale 1ns/1ps
module ssc_serial_port_control #(
  parameter logic [15:0] SAMPLE_DIV = 16'h0010
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxLineIn,
  output logic txLineOut,
  output logic txLineOeN,
  output logic syncClkOut,
  output logic syncClkOeN,
  output logic serialIrq
);
  ssc_pkg::ssc_ctrl_a_s ctrlA_r;
  ssc_pkg::ssc_ctrl_b_s ctrlB_r;
  ssc_pkg::ssc_status_s stat_r;
  ssc_pkg::ssc_tx_e txState_r, txNext;
  ssc_pkg::ssc_rx_e rxState_r;
  logic [15:0] sampCnt_r;
  logic sampleTick, bitTick, txDecide, txLoad, txEnPrev_r, prePend_r;
  logic [3:0] txPh_r, txIdx_r, rxPh_r, rxIdx_r, lastIdx, dLast;
  logic [ssc_pkg::TXSH_W-1:0] txSh_r, txFrame;
  logic [7:0] txHold_r, rxData_r, quietCnt_r, quietLimit;
  logic [8:0] rxSh_r;
  logic [2:0] vote_r, votes;
  logic rxBit, rxNoisy, rxNoise_r, rxDone, rxStop, rxMark, quietHit, lineQuiet;
  logic wakeQuiet, wakeMark, takeWord, allowed, quietArm_r, seen_r, clkActive;
  logic txLineOut_r, syncClk_r, oeN_r, brkReq_r;
  logic [31:0] prdata_r;
  logic access, mapped, wrA, wrB, wrData, rdData, rdStatus, swSleepWr;
  logic [7:0] idx;

  // length decoding shared by transmitter and receiver, and the transmitter's next-activity pick
  function automatic logic [3:0] frameLast(input logic nine);
    return nine ? ssc_pkg::LEN_9 - 4'h1 : ssc_pkg::LEN_8 - 4'h1;
  endfunction
  function automatic logic [3:0] dataLast(input logic nine);
    return nine ? ssc_pkg::DATA_9 : ssc_pkg::DATA_8;
  endfunction
  function automatic ssc_pkg::ssc_tx_e pickNext(input logic en, pend, brk, empty);
    if (!en) return ssc_pkg::TX_OFF;
    if (pend) return ssc_pkg::TX_PRE;
    if (brk) return ssc_pkg::TX_BRK;
    if (!empty) return ssc_pkg::TX_DATA;
    return ssc_pkg::TX_IDLE;
  endfunction

  assign lastIdx = frameLast(ctrlA_r.charLen);
  assign dLast = dataLast(ctrlA_r.charLen);

  // apb decode: byte address is four times the register index, no wait states
  assign access = psel && penable;
  assign idx = {2'b00, paddr[7:2]};
  assign mapped = (paddr[1:0] == 2'b00) && (idx == ssc_pkg::IDX_CTRL_A || idx == ssc_pkg::IDX_CTRL_B ||
                  idx == ssc_pkg::IDX_STATUS || idx == ssc_pkg::IDX_DATA);
  assign pready = access;
  assign pslverr = access && !mapped;
  assign wrA = access && pwrite && mapped && idx == ssc_pkg::IDX_CTRL_A;
  assign wrB = access && pwrite && mapped && idx == ssc_pkg::IDX_CTRL_B;
  assign wrData = access && pwrite && mapped && idx == ssc_pkg::IDX_DATA;
  assign rdData = access && !pwrite && mapped && idx == ssc_pkg::IDX_DATA;
  assign rdStatus = access && !pwrite && mapped && idx == ssc_pkg::IDX_STATUS;
  assign prdata = prdata_r;

  // read data is captured in the setup phase so the access phase answers at once
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (idx)
        ssc_pkg::IDX_CTRL_A: prdata_r <= {24'h00_0000, ctrlA_r};
        ssc_pkg::IDX_CTRL_B: prdata_r <= {24'h00_0000, ctrlB_r};
        ssc_pkg::IDX_STATUS: prdata_r <= {24'h00_0000, stat_r};
        ssc_pkg::IDX_DATA: prdata_r <= {24'h00_0000, rxData_r};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // control register a; the received ninth bit is hardware-owned and read-only
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrlA_r <= ssc_pkg::CTRL_A_RST;
    end else begin
      if (wrA) begin
        ctrlA_r <= (pwdata[7:0] & ssc_pkg::CTRL_A_WMASK) | (ctrlA_r & ~ssc_pkg::CTRL_A_WMASK);
      end
      if (takeWord && !stat_r.rxFull && !stat_r.frameErr) begin
        ctrlA_r.rxNinth <= rxSh_r[8];
      end
    end
  end

  // control register b; hardware wake is applied last so it wins over a write
  assign swSleepWr = wrB && pwdata[1] && !ctrlB_r.sleep;
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrlB_r <= ssc_pkg::CTRL_B_RST;
    end else begin
      if (wrB) begin
        ctrlB_r <= pwdata[7:0];
        if (swSleepWr && !ctrlA_r.rouse && lineQuiet) begin
          ctrlB_r.sleep <= 1'b0;
        end
      end
      if (wakeQuiet || wakeMark) begin
        ctrlB_r.sleep <= 1'b0;
      end
    end
  end

  // 16x sample tick divider; every slower rate derives from this enable
  assign sampleTick = sampCnt_r == SAMPLE_DIV - 16'h0001;
  always_ff @(posedge clk) begin
    if (srst || sampleTick) begin
      sampCnt_r <= 16'h0000;
    end else begin
      sampCnt_r <= sampCnt_r + 16'h0001;
    end
  end

  // transmit bit timing restarts on enable so the first bit is whole
  assign bitTick = sampleTick && txPh_r == ssc_pkg::OSR_LAST;
  always_ff @(posedge clk) begin
    if (srst || txState_r == ssc_pkg::TX_OFF) begin
      txPh_r <= 4'h0;
    end else if (sampleTick) begin
      txPh_r <= txPh_r + 4'h1;
    end
  end

  // next transmit activity is chosen only at a frame boundary, from idle, or after the mark bit
  assign txDecide = bitTick && (txState_r == ssc_pkg::TX_IDLE || txState_r == ssc_pkg::TX_MARK ||
                    (txState_r != ssc_pkg::TX_OFF && txIdx_r == lastIdx));
  always_comb begin
    txNext = pickNext(ctrlB_r.txEn, prePend_r, ctrlB_r.brk || brkReq_r, stat_r.txEmpty);
    if (txState_r == ssc_pkg::TX_BRK) begin
      txNext = (ctrlB_r.brk || brkReq_r) ? ssc_pkg::TX_BRK : ssc_pkg::TX_MARK;
    end
  end
  assign txLoad = txDecide && txNext == ssc_pkg::TX_DATA;
  assign txFrame = ctrlA_r.charLen ? {1'b1, ctrlA_r.txNinth, txHold_r, 1'b0} : {2'b11, txHold_r, 1'b0};

  // transmitter sequencing: preamble, data, break and the high bit after it
  always_ff @(posedge clk) begin
    if (srst) begin
      txState_r <= ssc_pkg::TX_OFF;
      txIdx_r <= 4'h0;
      txSh_r <= '1;
    end else if (txState_r == ssc_pkg::TX_OFF) begin
      if (ctrlB_r.txEn) begin
        txState_r <= ssc_pkg::TX_PRE;
        txIdx_r <= 4'h0;
        txSh_r <= '1;
      end
    end else if (txState_r == ssc_pkg::TX_IDLE && !ctrlB_r.txEn) begin
      txState_r <= ssc_pkg::TX_OFF;
    end else if (txDecide) begin
      txState_r <= txNext;
      txIdx_r <= 4'h0;
      if (txNext == ssc_pkg::TX_DATA) begin
        txSh_r <= txFrame;
      end else if (txNext == ssc_pkg::TX_BRK) begin
        txSh_r <= '0;
      end else begin
        txSh_r <= '1;
      end
    end else if (bitTick) begin
      txIdx_r <= txIdx_r + 4'h1;
      txSh_r <= {1'b1, txSh_r[ssc_pkg::TXSH_W-1:1]};
    end
  end

  // a re-enable while the pins are still busy asks for a fresh preamble
  always_ff @(posedge clk) begin
    if (srst) begin
      txEnPrev_r <= 1'b0;
      prePend_r <= 1'b0;
    end else begin
      txEnPrev_r <= ctrlB_r.txEn;
      if (txDecide && txNext == ssc_pkg::TX_PRE) begin
        prePend_r <= 1'b0;
      end
      if (ctrlB_r.txEn && !txEnPrev_r && txState_r != ssc_pkg::TX_OFF && txState_r != ssc_pkg::TX_IDLE) begin
        prePend_r <= 1'b1;
      end
    end
  end

  // a break bit set and cleared between frame boundaries still owes one whole block
  always_ff @(posedge clk) begin
    if (srst || txState_r == ssc_pkg::TX_OFF) begin
      brkReq_r <= 1'b0;
    end else if (ctrlB_r.brk) begin
      brkReq_r <= 1'b1;
    end else if (txDecide && txNext == ssc_pkg::TX_BRK) begin
      brkReq_r <= 1'b0;
    end
  end

  // clock pulses only on data bits; phase picks first or second half of the bit
  assign clkActive = txState_r == ssc_pkg::TX_DATA && txIdx_r != 4'h0 && txIdx_r <= dLast &&
                     (txIdx_r != dLast || ctrlA_r.finalClk) &&
                     (ctrlA_r.pha ? !txPh_r[3] : txPh_r[3]);

  // pin drivers are flops so the line never glitches on state changes
  always_ff @(posedge clk) begin
    if (srst) begin
      txLineOut_r <= 1'b1;
      syncClk_r <= 1'b0;
      oeN_r <= 1'b1;
    end else begin
      txLineOut_r <= txSh_r[0];
      syncClk_r <= ctrlA_r.pol ^ clkActive;
      oeN_r <= txState_r == ssc_pkg::TX_OFF;
    end
  end
  assign txLineOut = txLineOut_r;
  assign syncClkOut = syncClk_r;
  assign txLineOeN = oeN_r;
  assign syncClkOeN = oeN_r;

  // majority of three samples; disagreement marks noise
  assign votes = {vote_r[1:0], rxLineIn};
  assign rxBit = (votes[0] & votes[1]) | (votes[1] & votes[2]) | (votes[0] & votes[2]);
  assign rxNoisy = !(&votes) && (|votes);
  assign rxDone = sampleTick && rxState_r == ssc_pkg::RX_BITS && rxPh_r == ssc_pkg::OSR_VOTE &&
                  rxIdx_r == dLast + 4'h1;
  assign rxStop = rxBit;
  assign rxMark = rxSh_r[8];

  // receiver: hunts for a low, then walks start, data and stop bits
  always_ff @(posedge clk) begin
    if (srst) begin
      rxState_r <= ssc_pkg::RX_HUNT;
      rxPh_r <= 4'h0;
      rxIdx_r <= 4'h0;
      rxSh_r <= 9'h000;
      rxNoise_r <= 1'b0;
      vote_r <= 3'b111;
    end else if (sampleTick) begin
      vote_r <= votes;
      rxPh_r <= rxPh_r + 4'h1;
      if (rxState_r == ssc_pkg::RX_HUNT) begin
        if (!rxLineIn) begin
          rxState_r <= ssc_pkg::RX_BITS;
          rxPh_r <= ssc_pkg::RX_PH_START;
          rxIdx_r <= 4'h0;
          rxNoise_r <= 1'b0;
        end
      end else if (rxPh_r == ssc_pkg::OSR_VOTE) begin
        rxIdx_r <= rxIdx_r + 4'h1;
        rxNoise_r <= rxNoise_r | rxNoisy;
        if (rxIdx_r == 4'h0 && rxBit) begin
          rxState_r <= ssc_pkg::RX_HUNT; // false start, not counted as noise
        end else if (rxIdx_r != 4'h0 && rxIdx_r <= dLast) begin
          rxSh_r <= {rxBit, rxSh_r[8:1]};
        end else if (rxIdx_r != 4'h0) begin
          rxState_r <= ssc_pkg::RX_HUNT;
        end
      end
    end
  end

  // idle-line counter in sample ticks; saturates once a whole frame of ones passed
  assign quietLimit = {lastIdx + 4'h1, 4'h0};
  assign lineQuiet = quietCnt_r == quietLimit;
  assign quietHit = sampleTick && rxLineIn && rxState_r == ssc_pkg::RX_HUNT && quietCnt_r == quietLimit - 8'h01;
  always_ff @(posedge clk) begin
    if (srst) begin
      quietCnt_r <= 8'h00;
    end else if (sampleTick) begin
      if (!rxLineIn || rxState_r != ssc_pkg::RX_HUNT) begin
        quietCnt_r <= 8'h00;
      end else if (!lineQuiet) begin
        quietCnt_r <= quietCnt_r + 8'h01;
      end
    end
  end

  // wake conditions and the gate that keeps sleeping or disabled receivers silent
  assign wakeQuiet = quietHit && ctrlB_r.sleep && !ctrlA_r.rouse;
  assign wakeMark = rxDone && ctrlB_r.sleep && ctrlA_r.rouse && rxMark && ctrlB_r.rxEn;
  assign allowed = ctrlB_r.rxEn && !ctrlB_r.sleep;
  assign takeWord = rxDone && (allowed || wakeMark);

  // status read then data access arms the flag clears
  always_ff @(posedge clk) begin
    if (srst) begin
      seen_r <= 1'b0;
    end else if (rdStatus) begin
      seen_r <= 1'b1;
    end else if (rdData || wrData) begin
      seen_r <= 1'b0;
    end
  end

  // status flags and holding registers share one process; a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (srst) begin
      txHold_r <= 8'h00;
      stat_r.txEmpty <= 1'b1;
      stat_r.txDone <= 1'b1;
    end else begin
      if (wrData) begin
        txHold_r <= pwdata[7:0];
        if (seen_r) begin
          stat_r.txEmpty <= stat_r.txEmpty ? 1'b0 : stat_r.txEmpty;
          stat_r.txDone <= 1'b0;
        end
      end
      if (txLoad) begin
        stat_r.txEmpty <= 1'b1;
      end
      if (txDecide && txNext == ssc_pkg::TX_IDLE) begin
        stat_r.txDone <= 1'b1;
      end
    end
    // receiver flags; disabled receivers never set one, sleeping ones only on an address-mark wake, and none is cleared by sleep
    if (srst) begin
      stat_r.rxFull <= 1'b0;
      stat_r.quiet <= 1'b0;
      stat_r.overrun <= 1'b0;
      stat_r.noise <= 1'b0;
      stat_r.frameErr <= 1'b0;
      stat_r.spare <= 1'b0;
      quietArm_r <= 1'b0;
      rxData_r <= 8'h00;
    end else begin
      if (rdData && seen_r) begin
        stat_r.rxFull <= 1'b0;
        stat_r.quiet <= 1'b0;
        stat_r.overrun <= 1'b0;
        stat_r.noise <= 1'b0;
        stat_r.frameErr <= 1'b0;
      end
      if (takeWord) begin
        if (stat_r.rxFull || stat_r.frameErr) begin
          stat_r.overrun <= 1'b1; // word lost, holding data kept
        end else begin
          stat_r.rxFull <= 1'b1;
          stat_r.frameErr <= !rxStop;
          stat_r.noise <= rxNoise_r | rxNoisy;
          rxData_r <= ctrlA_r.charLen ? rxSh_r[7:0] : rxSh_r[8:1];
          quietArm_r <= 1'b1;
        end
      end
      if (quietHit && allowed && quietArm_r) begin
        stat_r.quiet <= 1'b1;
        quietArm_r <= 1'b0;
      end
    end
  end

  // one request line; each flag but noise and frameErr passes only through its enable, overrun through rxIe
  assign serialIrq = (stat_r.txEmpty && ctrlB_r.txeIe) || (stat_r.txDone && ctrlB_r.tx_done_int_en) ||
                     ((stat_r.rxFull || stat_r.overrun) && ctrlB_r.rxIe) || (stat_r.quiet && ctrlB_r.quietIe);

  // checks kept beside the logic they guard
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence s_enRise;
    txState_r == ssc_pkg::TX_OFF && ctrlB_r.txEn;
  endsequence
  sequence s_preambleHigh;
    txState_r == ssc_pkg::TX_PRE ##1 txLineOut_r && !txLineOeN;
  endsequence
  property p_enable_pre;
    s_enRise |=> s_preambleHigh;
  endproperty
  a_enable_pre: assert property (p_enable_pre) else $error("no preamble after enable");
  property p_finish_char;
    txState_r == ssc_pkg::TX_DATA && !bitTick |=> txState_r == ssc_pkg::TX_DATA;
  endproperty
  a_finish_char: assert property (p_finish_char) else $error("character cut short");
  property p_break_low;
    txState_r == ssc_pkg::TX_BRK |=> !txLineOut_r;
  endproperty
  a_break_low: assert property (p_break_low) else $error("break bit not low");
  property p_clk_rest;
    txState_r != ssc_pkg::TX_DATA |=> syncClkOut == $past(ctrlA_r.pol);
  endproperty
  a_clk_rest: assert property (p_clk_rest) else $error("sync clock active outside data");
  property p_frame_edges;
    txState_r == ssc_pkg::TX_DATA && (txIdx_r == 4'h0 || txIdx_r == lastIdx) |=> syncClkOut == $past(ctrlA_r.pol);
  endproperty
  a_frame_edges: assert property (p_frame_edges) else $error("clock on start or stop bit");
  property p_last_clk;
    txState_r == ssc_pkg::TX_DATA && txIdx_r == dLast && !ctrlA_r.finalClk |=> syncClkOut == $past(ctrlA_r.pol);
  endproperty
  a_last_clk: assert property (p_last_clk) else $error("last bit clocked while disabled");
  property p_load_ninth;
    txLoad && ctrlA_r.charLen |=> txSh_r[9] == $past(ctrlA_r.txNinth) && txState_r == ssc_pkg::TX_DATA;
  endproperty
  a_load_ninth: assert property (p_load_ninth) else $error("ninth bit not loaded");
  property p_rx_gate;
    $rose(stat_r.rxFull) |-> $past(ctrlB_r.rxEn);
  endproperty
  a_rx_gate: assert property (p_rx_gate) else $error("flag set while receiver off");
  property p_sleep_quiet;
    $rose(stat_r.quiet) |-> !$past(ctrlB_r.sleep);
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("idle flag set while asleep");
  property p_sleep_block;
    swSleepWr && !ctrlA_r.rouse && lineQuiet |=> !ctrlB_r.sleep;
  endproperty
  a_sleep_block: assert property (p_sleep_block) else $error("sleep set on idle line");
  property p_quiet_wake;
    wakeQuiet |=> !ctrlB_r.sleep;
  endproperty
  a_quiet_wake: assert property (p_quiet_wake) else $error("no idle-line wake");
  property p_mark_wake;
    wakeMark && !stat_r.rxFull && !stat_r.frameErr |=> !ctrlB_r.sleep && stat_r.rxFull;
  endproperty
  a_mark_wake: assert property (p_mark_wake) else $error("no address-mark wake");
  property p_irq;
    (stat_r.rxFull && ctrlB_r.rxIe) || (stat_r.txEmpty && ctrlB_r.txeIe) |-> serialIrq;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled flag without request");
endmodule

// *** test/ssc_remote_peer.sv ***
// remote serial transceiver model facing the serial port pins
`timescale 1ns/1ps
module ssc_remote_peer #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk,
  output logic peerTx,
  input wire logic dutTx,
  input wire logic dutTxOeN
);
  // a released transmit pin is pulled up, so the peer sees mark then
  wire logic lineSeen = dutTxOeN ? 1'b1 : dutTx;

  // idle line rests high between frames
  initial peerTx = 1'b1;

  // start bit, lsb first data, one stop bit
  task automatic send_char(input int nb, input logic [8:0] ch);
    for (int i = 0; i < nb + 2; i++) begin
      @(posedge clk);
      peerTx <= (i == 0) ? 1'b0 : (i > nb) ? 1'b1 : ch[i-1];
      repeat (BIT_CLKS - 1) @(posedge clk);
    end
  endtask

  // samples mid-bit after the falling start edge; stop bit lands in ch[nb]
  task automatic recv_char(input int nb, output logic [9:0] ch, output int waited);
    waited = 0;
    ch = 10'h000;
    while (lineSeen !== 1'b0) begin
      @(posedge clk);
      waited++;
    end
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i <= nb; i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      ch[i] = lineSeen;
    end
  endtask
endmodule

// *** test/ssc_serial_port_control_tb_top.sv ***
// self-checking bench for the serial port control block
`timescale 1ns/1ps
module ssc_serial_port_control_tb_top;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] w;
    logic [7:0] r;
    logic err;
    logic irq;
  } ssc_row_s;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rxLineIn;
  logic txLineOut;
  logic txLineOeN;
  logic syncClkOut;
  logic syncClkOeN;
  logic serialIrq;
  logic clkRest = 1'b0;
  logic syncPrev = 1'b0;
  logic [31:0] rd;
  logic err;
  logic [9:0] got;
  int waited;
  int pulseCnt = 0;
  int mismatches = 0;
  int testsRun = 0;
  // address, write value, read back, slave error, interrupt
  ssc_row_s rows [5] = '{
    '{8'h38, 8'hff, 8'h5f, 1'b0, 1'b0},
    '{8'h3c, 8'h80, 8'h80, 1'b0, 1'b1},
    '{8'h3c, 8'h40, 8'h40, 1'b0, 1'b1},
    '{8'h3c, 8'h30, 8'h30, 1'b0, 1'b0},
    '{8'h50, 8'hff, 8'h00, 1'b1, 1'b0}};
  wire logic txSeen = txLineOeN ? 1'b1 : txLineOut;

  always #2 clk = ~clk;

  ssc_serial_port_control #(.SAMPLE_DIV(16'h0001)) ssc_serial_port_control_inst (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxLineIn(rxLineIn), .txLineOut(txLineOut), .txLineOeN(txLineOeN),
    .syncClkOut(syncClkOut), .syncClkOeN(syncClkOeN), .serialIrq(serialIrq));

  ssc_remote_peer #(.BIT_CLKS(16)) ssc_remote_peer_inst (
    .clk(clk), .peerTx(rxLineIn), .dutTx(txLineOut), .dutTxOeN(txLineOeN));

  // counts departures of the sync clock from its rest level
  always @(posedge clk) begin
    if (syncClkOut !== clkRest && syncPrev === clkRest) pulseCnt <= pulseCnt + 1;
    syncPrev <= syncClkOut;
  end

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    testsRun++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one apb transfer; read data and error are taken at the pready edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rcheck(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check(rd, {24'h0, e});
  endtask

  // idle bit is masked: it rises on its own once the line rests
  task automatic rx_case(input logic [7:0] ca, input logic [7:0] cb, input int nb, input logic [8:0] ch);
    bus(1'b1, 8'h38, ca);
    bus(1'b1, 8'h3c, cb);
    ssc_remote_peer_inst.send_char(nb, ch);
    repeat (4) @(posedge clk);
    bus(1'b0, 8'h40, 8'h00);
    rd = rd & 32'h2e;
  endtask

  task automatic give_verdict();
    $display("tests run %0d, mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // the whole run takes far less than this span; only a hang reaches it
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    check({txLineOeN, syncClkOeN, syncClkOut, serialIrq}, 4'hc);
    rcheck(8'h3c, 8'h00);
    rcheck(8'h40, 8'hc0);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].w);
      bus(1'b0, rows[i].a, 8'h00);
      check({rd[7:0], err, serialIrq}, {rows[i].r, rows[i].err, rows[i].irq});
    end
    check(syncClkOut, 1'b1);
    // receive in both formats, then with the receiver off
    rx_case(8'h00, 8'h04, 8, 9'h0a5);
    check(rd, 32'h20);
    rcheck(8'h44, 8'ha5);
    rx_case(8'h10, 8'h04, 9, 9'h13c);
    check(rd, 32'h20);
    rcheck(8'h44, 8'h3c);
    rcheck(8'h38, 8'h90);
    rx_case(8'h00, 8'h00, 8, 9'h055);
    check(rd, 32'h0);
    repeat (170) @(posedge clk);
    bus(1'b1, 8'h3c, 8'h06);
    rcheck(8'h3c, 8'h04);
    // sleep taken mid-character wakes only after ten quiet bits
    fork
      ssc_remote_peer_inst.send_char(8, 9'h000);
      begin
        repeat (40) @(posedge clk);
        bus(1'b1, 8'h3c, 8'h06);
      end
    join
    repeat (100) @(posedge clk);
    rcheck(8'h3c, 8'h06);
    repeat (100) @(posedge clk);
    rcheck(8'h3c, 8'h04);
    rx_case(8'h08, 8'h06, 8, 9'h012);
    check(rd, 32'h0);
    ssc_remote_peer_inst.send_char(8, 9'h092);
    repeat (4) @(posedge clk);
    bus(1'b0, 8'h40, 8'h00);
    check(rd & 32'h2e, 32'h20);
    rcheck(8'h44, 8'h92);
    rcheck(8'h3c, 8'h04);
    // transmit with preamble, then a frame finished after disabling mid-character
    bus(1'b1, 8'h38, 8'h04);
    clkRest <= 1'b1;
    bus(1'b0, 8'h40, 8'h00);
    bus(1'b1, 8'h44, 8'h5a);
    pulseCnt <= 0;
    bus(1'b1, 8'h3c, 8'h0c);
    ssc_remote_peer_inst.recv_char(8, got, waited);
    check({got, txLineOeN, syncClkOeN}, {10'h15a, 2'b00});
    check(waited >= 155 && waited <= 180, 1'b1);
    check(pulseCnt, 7);
    bus(1'b0, 8'h40, 8'h00);
    bus(1'b1, 8'h44, 8'hc3);
    pulseCnt <= 0;
    fork
      ssc_remote_peer_inst.recv_char(8, got, waited);
      begin
        wait (txSeen === 1'b0);
        bus(1'b1, 8'h3c, 8'h04);
      end
    join
    check(got, 10'h1c3);
    check(pulseCnt, 7);
    repeat (20) @(posedge clk);
    check({txLineOeN, syncClkOeN}, 2'b11);
    // nine-bit frame with the ninth bit set, clocks at bit start, last bit clocked too
    bus(1'b1, 8'h38, 8'h57);
    bus(1'b0, 8'h40, 8'h00);
    bus(1'b1, 8'h44, 8'h96);
    pulseCnt <= 0;
    bus(1'b1, 8'h3c, 8'h0c);
    ssc_remote_peer_inst.recv_char(9, got, waited);
    check(got, 10'h396);
    check(pulseCnt, 9);
    check(waited >= 171 && waited <= 196, 1'b1);
    bus(1'b1, 8'h3c, 8'h04);
    repeat (20) @(posedge clk);
    // a break pulse in nine-bit format, no sync clocks meanwhile
    bus(1'b1, 8'h38, 8'h10);
    clkRest <= 1'b0;
    pulseCnt <= 0;
    bus(1'b1, 8'h3c, 8'h08);
    bus(1'b1, 8'h3c, 8'h09);
    bus(1'b1, 8'h3c, 8'h08);
    wait (txSeen === 1'b0);
    waited = 0;
    @(negedge clk);
    while (txSeen === 1'b0) begin
      waited++;
      @(negedge clk);
    end
    check(waited, 176);
    repeat (14) @(negedge clk);
    check({txSeen, pulseCnt[7:0]}, 9'h100);
    give_verdict();
  end
endmodule
